// ===== src/piorc_defines.vh
// Purpose: constants of the process io relay control block
// Assumes: 125 MHz clock, AHB-Lite register access
// Notes: times kept in their own unit, cycle counts derived
// What this block does
// - Test voltage only while permit contact closed
// - Reset contact closure clears any-fault relay
// - HV relay closed above 500 V
// - Fault sets relay; latched until reset
// - Timed mode: fault relay ends after duration
// - Window relay closed between low/high thresholds
// - Bare wire fault sets relay; latched until reset
// - Timed mode: bare wire relay ends after duration
`ifndef PIORC_DEFINES_VH
`define PIORC_DEFINES_VH
`define PIORC_CLK_MHZ         125
`define PIORC_RST_MIN_MS      50
`define PIORC_RST_CYC         (`PIORC_RST_MIN_MS * 1000 * `PIORC_CLK_MHZ)
`define PIORC_PERMIT_US       1
`define PIORC_PERMIT_CYC      (`PIORC_PERMIT_US * `PIORC_CLK_MHZ)
`define PIORC_HV_MIN_V        16'h01f4
`define PIORC_TICK_US         1000
`define PIORC_TICK_CYC        (`PIORC_TICK_US * `PIORC_CLK_MHZ)
`define PIORC_A_CTRL          8'h00
`define PIORC_A_WLOW          8'h04
`define PIORC_A_WHIGH         8'h08
`define PIORC_A_FDUR          8'h0c
`define PIORC_A_BDUR          8'h10
`define PIORC_A_STAT          8'h14
`define PIORC_A_IMASK         8'h18
`define PIORC_A_ISTAT         8'h1c
`define PIORC_MODE_LATCH      2'h0
`define PIORC_MODE_RESETREQ   2'h1
`define PIORC_MODE_TIMED      2'h2
`define PIORC_CTRL_RST        2'h0
`define PIORC_IMASK_RST       4'h0
`define PIORC_ISTAT_RST       4'h0
`define PIORC_WLOW_RST        16'h0000
`define PIORC_WHIGH_RST       16'hffff
`define PIORC_DUR_RST         16'h03e8
`endif

// ===== src/piorc_top.v
// Purpose: relay outputs and contact inputs of an insulation tester
// Assumes: measured voltage and fault events synchronous to clk
// Notes: durations counted in 1 ms ticks
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "piorc_defines.vh"
module piorc_top #(
    parameter RST_CYC    = `PIORC_RST_CYC,
    parameter TICK_CYC   = `PIORC_TICK_CYC,
    parameter PERMIT_CYC = `PIORC_PERMIT_CYC
) (
    // clock and reset
    input  wire        clk,
    input  wire        nrst,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // contacts, high level means closed
    input  wire        hv_permit_input,
    input  wire        external_reset_input,
    // measurement and detection
    input  wire [15:0] test_voltage,
    input  wire        fault_event,
    input  wire        bare_wire_event,
    input  wire        panel_reset,
    // outputs
    output reg         hv_drive_enable,
    output reg         hv_present_relay,
    output reg         any_fault_relay,
    output reg         voltage_window_relay,
    output reg         bare_wire_relay,
    output reg         irq
);
    localparam CW = 32;

    // registers
    reg  [1:0]  mode_r;
    reg  [15:0] wlow_r;
    reg  [15:0] whigh_r;
    reg  [15:0] fdur_r;
    reg  [15:0] bdur_r;
    reg  [3:0]  imask_r;
    reg  [3:0]  istat_r;
    reg  [3:0]  istat_nxt;
    reg  [31:0] rdata_nxt;

    // bus address phase capture
    reg         wr_pend_r;
    reg         rd_pend_r;
    reg  [7:0]  addr_r;

    // contact sync and debounce
    reg  [1:0]  perm_sync_r;
    reg  [1:0]  rst_sync_r;
    reg         perm_stable_r;
    reg         rst_stable_r;
    reg         rst_stable_d_r;
    reg  [CW-1:0] perm_cnt_r;
    reg  [CW-1:0] rst_cnt_r;

    // alarm timing
    reg  [CW-1:0] tick_cnt_r;
    reg         tick_r;
    reg  [15:0] ftime_r;
    reg  [15:0] btime_r;

    wire        ext_reset_pulse;
    wire        clr_all;
    wire        timed;
    wire        in_window;
    wire        hv_above;
    wire        addr_ok;
    wire        rd_istat;

    assign ext_reset_pulse = rst_stable_r & ~rst_stable_d_r;
    assign clr_all   = ext_reset_pulse | panel_reset;
    assign timed     = (mode_r == `PIORC_MODE_TIMED);
    assign in_window = (test_voltage >= wlow_r) && (test_voltage <= whigh_r);
    assign hv_above  = (test_voltage > `PIORC_HV_MIN_V);
    assign addr_ok   = hsel & hready & htrans[1];
    assign rd_istat  = rd_pend_r && (addr_r == `PIORC_A_ISTAT);

    // contact synchronisers and debounce
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            perm_sync_r    <= 2'h0;
            rst_sync_r     <= 2'h0;
            perm_stable_r  <= 1'b0;
            rst_stable_r   <= 1'b0;
            rst_stable_d_r <= 1'b0;
            perm_cnt_r     <= {CW{1'b0}};
            rst_cnt_r      <= {CW{1'b0}};
        end
        else
        begin
            perm_sync_r    <= {perm_sync_r[0], hv_permit_input};
            rst_sync_r     <= {rst_sync_r[0], external_reset_input};
            rst_stable_d_r <= rst_stable_r;
            // opening drops permit at once; closing must settle
            if (!perm_sync_r[1])
            begin
                perm_stable_r <= 1'b0;
                perm_cnt_r    <= {CW{1'b0}};
            end
            else if (perm_cnt_r >= PERMIT_CYC[CW-1:0] - 1'b1)
                perm_stable_r <= 1'b1;
            else
                perm_cnt_r <= perm_cnt_r + 1'b1;
            // reset accepted only after full hold time
            if (!rst_sync_r[1])
            begin
                rst_stable_r <= 1'b0;
                rst_cnt_r    <= {CW{1'b0}};
            end
            else if (rst_cnt_r >= RST_CYC[CW-1:0] - 1'b1)
                rst_stable_r <= 1'b1;
            else
                rst_cnt_r <= rst_cnt_r + 1'b1;
        end
    end

    // millisecond tick for alarm durations
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt_r <= {CW{1'b0}};
            tick_r     <= 1'b0;
        end
        else if (tick_cnt_r >= TICK_CYC[CW-1:0] - 1'b1)
        begin
            tick_cnt_r <= {CW{1'b0}};
            tick_r     <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r     <= 1'b0;
        end
    end

    // alarm relays; a new event wins over a clear
    // first tick after an event may be partial, so a duration can end one tick early
    // a clear restarts the elapsed time so a later timed run starts fresh
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            any_fault_relay <= 1'b0;
            bare_wire_relay <= 1'b0;
            ftime_r         <= 16'h0000;
            btime_r         <= 16'h0000;
        end
        else
        begin
            if (fault_event)
            begin
                any_fault_relay <= 1'b1;
                ftime_r         <= 16'h0000;
            end
            else if (clr_all)
            begin
                any_fault_relay <= 1'b0;
                ftime_r         <= 16'h0000;
            end
            else if (timed && any_fault_relay && tick_r)
            begin
                if (ftime_r + 16'h0001 >= fdur_r)
                    any_fault_relay <= 1'b0;
                ftime_r <= ftime_r + 16'h0001;
            end
            if (bare_wire_event)
            begin
                bare_wire_relay <= 1'b1;
                btime_r         <= 16'h0000;
            end
            else if (clr_all)
            begin
                bare_wire_relay <= 1'b0;
                btime_r         <= 16'h0000;
            end
            else if (timed && bare_wire_relay && tick_r)
            begin
                if (btime_r + 16'h0001 >= bdur_r)
                    bare_wire_relay <= 1'b0;
                btime_r <= btime_r + 16'h0001;
            end
        end
    end

    // level outputs
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hv_drive_enable      <= 1'b0;
            hv_present_relay     <= 1'b0;
            voltage_window_relay <= 1'b0;
            irq                  <= 1'b0;
        end
        else
        begin
            // permit re-checked so an opening contact cuts drive before debounce
            hv_drive_enable      <= perm_stable_r & perm_sync_r[1];
            hv_present_relay     <= hv_above;
            voltage_window_relay <= in_window;
            irq                  <= |(istat_nxt & imask_r);
        end
    end

    // interrupt status: fault, bare wire, reset accepted, permit lost
    always @*
    begin
        istat_nxt = istat_r;
        // a set in the same cycle as the clearing read survives
        if (rd_istat)
            istat_nxt = 4'h0;
        istat_nxt = istat_nxt | {perm_stable_r & ~perm_sync_r[1],
                                 ext_reset_pulse, bare_wire_event, fault_event};
    end

    // ahb-lite slave, zero wait states
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            istat_r   <= `PIORC_ISTAT_RST;
        end
        else
        begin
            istat_r   <= istat_nxt;
            wr_pend_r <= addr_ok & hwrite;
            rd_pend_r <= addr_ok & ~hwrite;
            if (addr_ok)
                addr_r <= haddr[7:0];
            if (addr_ok & ~hwrite)
                hrdata <= rdata_nxt;
        end
    end

    // read data, taken in the address phase
    // status read returns the next value so no event is lost
    always @*
    begin
        rdata_nxt = 32'h00000000;
        case (haddr[7:0])
            `PIORC_A_CTRL:  rdata_nxt = {30'h0, mode_r};
            `PIORC_A_WLOW:  rdata_nxt = {16'h0, wlow_r};
            `PIORC_A_WHIGH: rdata_nxt = {16'h0, whigh_r};
            `PIORC_A_FDUR:  rdata_nxt = {16'h0, fdur_r};
            `PIORC_A_BDUR:  rdata_nxt = {16'h0, bdur_r};
            `PIORC_A_STAT:  rdata_nxt = {26'h0, perm_stable_r, hv_drive_enable,
                                         bare_wire_relay, voltage_window_relay,
                                         any_fault_relay, hv_present_relay};
            `PIORC_A_IMASK: rdata_nxt = {28'h0, imask_r};
            `PIORC_A_ISTAT: rdata_nxt = {28'h0, istat_nxt};
            default:        rdata_nxt = 32'h00000000;
        endcase
    end

    // register writes land in the data phase
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_r  <= `PIORC_CTRL_RST;
            wlow_r  <= `PIORC_WLOW_RST;
            whigh_r <= `PIORC_WHIGH_RST;
            fdur_r  <= `PIORC_DUR_RST;
            bdur_r  <= `PIORC_DUR_RST;
            imask_r <= `PIORC_IMASK_RST;
        end
        else if (wr_pend_r)
        begin
            case (addr_r)
                `PIORC_A_CTRL:
                    if (hwdata[1:0] != 2'h3)
                        mode_r <= hwdata[1:0];
                `PIORC_A_WLOW:  wlow_r  <= hwdata[15:0];
                `PIORC_A_WHIGH: whigh_r <= hwdata[15:0];
                `PIORC_A_FDUR:  fdur_r  <= hwdata[15:0];
                `PIORC_A_BDUR:  bdur_r  <= hwdata[15:0];
                `PIORC_A_IMASK: imask_r <= hwdata[3:0];
                default:        mode_r  <= mode_r;
            endcase
        end
    end
endmodule // piorc_top

// ===== bench/piorc_monitor.sv
// Purpose: port checks of the relay block
// Assumes: bound into piorc_top
// Notes: reset hold count scaled down
`timescale 1ns/100ps
module piorc_monitor #(parameter RST_CYC = 20) (
    // clock and reset
    input wire        clk,
    input wire        nrst,
    // contacts and events
    input wire        external_reset_input,
    input wire        hv_permit_input,
    input wire [15:0] test_voltage,
    input wire        fault_event,
    input wire        bare_wire_event,
    input wire        panel_reset,
    // outputs
    input wire        hreadyout,
    input wire        hresp,
    input wire        hv_drive_enable,
    input wire        hv_present_relay,
    input wire        any_fault_relay,
    input wire        bare_wire_relay
);
    reg  [7:0] held_r;
    wire       ev = fault_event | bare_wire_event;
    // cycles the reset contact stayed closed; an event after its clear pulse parks it
    always @(posedge clk or negedge nrst)
        if (!nrst)
            held_r <= 8'h00;
        else if (!external_reset_input)
            held_r <= 8'h00;
        else if (ev && held_r >= RST_CYC + 2)
            held_r <= 8'hff;
        else if (held_r != 8'hff)
            held_r <= held_r + 8'h01;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_quiet; !ev [*3]; endsequence
    sequence s_panel; panel_reset && !ev ##1 s_quiet; endsequence
    property p_hv_level; 1 |=> hv_present_relay == ($past(test_voltage) > 16'h01f4); endproperty
    property p_hv_off; !hv_permit_input [*4] |=> !hv_drive_enable; endproperty
    property p_fault_set; fault_event |=> any_fault_relay; endproperty
    property p_bare_set; bare_wire_event |=> bare_wire_relay; endproperty
    property p_ext_clr; {24'h0, held_r} == RST_CYC + 8 |-> !any_fault_relay && !bare_wire_relay;
    endproperty
    property p_panel_fault; s_panel |-> !any_fault_relay; endproperty
    property p_panel_bare; s_panel |-> !bare_wire_relay; endproperty
    property p_okay; 1 |-> hreadyout && !hresp; endproperty
    a_hv_level: assert property (p_hv_level) else $error("hv relay wrong");
    a_hv_off: assert property (p_hv_off) else $error("drive without permit");
    a_fault_set: assert property (p_fault_set) else $error("fault relay not set");
    a_bare_set: assert property (p_bare_set) else $error("bare relay not set");
    a_ext_clr: assert property (p_ext_clr) else $error("ext reset no clear");
    a_panel_fault: assert property (p_panel_fault) else $error("panel no clear");
    a_panel_bare: assert property (p_panel_bare) else $error("panel no clear");
    a_okay: assert property (p_okay) else $error("bus not ready");
endmodule // piorc_monitor
bind piorc_top piorc_monitor #(.RST_CYC(RST_CYC)) u_mon (.clk(clk), .nrst(nrst),
    .external_reset_input(external_reset_input), .hv_permit_input(hv_permit_input),
    .test_voltage(test_voltage), .fault_event(fault_event), .bare_wire_event(bare_wire_event),
    .panel_reset(panel_reset), .hreadyout(hreadyout), .hresp(hresp),
    .hv_drive_enable(hv_drive_enable), .hv_present_relay(hv_present_relay),
    .any_fault_relay(any_fault_relay), .bare_wire_relay(bare_wire_relay));

// ===== bench/piorc_field.sv
// Purpose: line controller and reset switch
// Assumes: open contact reads low
// Notes: reset press held hold_len cycles
`timescale 1ns/100ps
module piorc_field (
    // commands
    input wire       clk,
    input wire       line_run,
    input wire       press,
    input wire [7:0] hold_len,
    // contacts
    output reg       hv_permit_input,
    output reg       external_reset_input
);
    reg [7:0] left_r = 8'h00;
    initial hv_permit_input = 1'b0;
    initial external_reset_input = 1'b0;
    always @(posedge clk)
    begin
        hv_permit_input <= line_run;
        if (press)
            left_r <= hold_len;
        else if (left_r != 8'h00)
            left_r <= left_r - 8'h01;
        external_reset_input <= press || left_r > 8'h01;
    end
endmodule // piorc_field

// ===== bench/piorc_tb_top.sv
// Purpose: self-checking bench of piorc_top
// Assumes: scaled counts 20, 4, 2
// Notes: seed 78
`timescale 1ns/100ps
module piorc_tb_top;
    reg         clk, nrst, hsel, hwrite, fault_event, bare_wire_event, panel_reset;
    reg         line_run, press;
    reg  [31:0] haddr, hwdata, r;
    reg  [1:0]  htrans;
    reg  [15:0] test_voltage, lo, hi, v;
    reg  [7:0]  hold_len, a;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, hv_permit_input, external_reset_input, hv_drive_enable;
    wire        hv_present_relay, any_fault_relay, voltage_window_relay, bare_wire_relay, irq;
    integer     fail_count, n_checks, i, m;
    piorc_top #(.RST_CYC(20), .TICK_CYC(4), .PERMIT_CYC(2)) uut (.clk(clk), .nrst(nrst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .hv_permit_input(hv_permit_input), .test_voltage(test_voltage),
        .external_reset_input(external_reset_input), .fault_event(fault_event),
        .bare_wire_event(bare_wire_event), .panel_reset(panel_reset), .irq(irq),
        .hv_drive_enable(hv_drive_enable), .hv_present_relay(hv_present_relay),
        .any_fault_relay(any_fault_relay), .voltage_window_relay(voltage_window_relay),
        .bare_wire_relay(bare_wire_relay));
    piorc_field u_field (.clk(clk), .line_run(line_run), .press(press), .hold_len(hold_len),
        .hv_permit_input(hv_permit_input), .external_reset_input(external_reset_input));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task bus(input wr, input [7:0] ad, input [31:0] d);
    begin
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, ad};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    end
    endtask
    task pulse_events;
    begin
        fault_event <= 1'b1;
        bare_wire_event <= 1'b1;
        cyc(1);
        fault_event <= 1'b0;
        bare_wire_event <= 1'b0;
    end
    endtask
    function [31:0] rst_val(input [7:0] ad);
        rst_val = (ad == 8'h08) ? 32'hffff : (ad == 8'h0c || ad == 8'h10) ? 32'h3e8 :
                  (ad == 8'h14) ? 32'h4 : 32'h0;
    endfunction
    task end_sim;
    begin
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    initial
    begin
        // whole run is well under 2000 cycles
        #100000;
        fail_count = fail_count + 1;
        end_sim;
    end
    initial
    begin
        {nrst, hsel, hwrite, fault_event, bare_wire_event, panel_reset, line_run, press} = 0;
        {haddr, hwdata, htrans, test_voltage, hold_len} = 0;
        fail_count = 0;
        n_checks = 0;
        r = $urandom(78);
        cyc(3);
        nrst <= 1'b1;
        bus(1'b1, 8'h20, $urandom);
        for (a = 8'h00; a < 8'h24; a = a + 8'h04)
        begin
            bus(1'b0, a, 32'h0);
            chk(r, rst_val(a));
        end
        line_run <= 1'b1;
        cyc(12);
        chk(hv_drive_enable, 1'b1);
        line_run <= 1'b0;
        cyc(6);
        chk(hv_drive_enable, 1'b0);
        bus(1'b0, 8'h1c, 32'h0);
        chk(r, 32'h8);
        lo = 16'd400 + $urandom % 100;
        hi = lo + 16'd50 + $urandom % 100;
        bus(1'b1, 8'h04, {16'h0, lo});
        bus(1'b1, 8'h08, {16'h0, hi});
        for (i = 0; i < 16; i = i + 1)
        begin
            case (i)
                0: v = lo;
                1: v = hi;
                2: v = hi + 16'd1;
                3: v = lo - 16'd1;
                4: v = 16'h01f4;
                5: v = 16'h01f5;
                default: v = $urandom % 1100;
            endcase
            test_voltage <= v;
            cyc(3);
            chk(hv_present_relay, v > 16'h01f4);
            chk(voltage_window_relay, v >= lo && v <= hi);
        end
        for (m = 0; m < 2; m = m + 1)
        begin
            bus(1'b1, 8'h00, m);
            bus(1'b1, 8'h18, 32'h1);
            pulse_events;
            cyc(40);
            chk({any_fault_relay, bare_wire_relay, irq}, 3'h7);
            if (m == 0)
            begin
                hold_len <= 8'd10;
                press <= 1'b1;
                cyc(1);
                press <= 1'b0;
                cyc(30);
                chk(any_fault_relay, 1'b1);
                hold_len <= 8'd40;
                press <= 1'b1;
                cyc(1);
                press <= 1'b0;
                cyc(60);
            end
            else
            begin
                panel_reset <= 1'b1;
                cyc(1);
                panel_reset <= 1'b0;
                cyc(4);
            end
            chk({any_fault_relay, bare_wire_relay}, 2'h0);
            bus(1'b0, 8'h1c, 32'h0);
            chk(r, m ? 32'h3 : 32'h7);
            cyc(2);
            chk(irq, 1'b0);
        end
        bus(1'b1, 8'h00, 32'h2);
        bus(1'b1, 8'h0c, 32'h3);
        bus(1'b1, 8'h10, 32'h5);
        bus(1'b1, 8'h18, 32'h0);
        bus(1'b1, 8'h00, 32'h3);
        bus(1'b0, 8'h00, 32'h0);
        chk(r, 32'h2);
        pulse_events;
        cyc(6);
        chk({any_fault_relay, bare_wire_relay, irq}, 3'h6);
        cyc(8);
        chk({any_fault_relay, bare_wire_relay}, 2'h1);
        cyc(8);
        chk({any_fault_relay, bare_wire_relay, irq}, 3'h0);
        end_sim;
    end
endmodule // piorc_tb_top
